// File: misc_strap_consts.svh
// Constants for the miscellaneous pin and strap block
`ifndef MISC_STRAP_CONSTS_SVH
`define MISC_STRAP_CONSTS_SVH

// ==========================================
// Register offsets (word index, byte address = 4 x index)
`define REG_GP_DIR 4'h0
`define REG_GP_OUT 4'h1
`define REG_GP_IN 4'h2
`define REG_STATUS 4'h3
`define REG_EE_CTRL 4'h4
`define REG_PORT_STAT 4'h5

// ==========================================
// Field positions and reset values
`define GP_WIDTH 8
`define SMB_ADDR_LSB 5
`define DBG_SEL_LSB 0
`define DBG_SEL_W 5
`define NUM_PORTS 3
`define GP_DIR_RST 8'h00
`define GP_OUT_RST 8'h00
`define ST_PWR_SAVE 0
`define ST_DEBUG 1
`define ST_SCAN 2
`define ST_PSTAT_EN 3
`define EE_GO 0
`define EE_WR 1

// ==========================================
// Timing
`define CLK_PERIOD_NS 10
`define EE_CLK_NS 1000
`define EE_HALF_CYC ((`EE_CLK_NS / 2) / `CLK_PERIOD_NS)
`define EE_BITS 8

`endif

// File: misc_strap_pkg.sv
// Types for the miscellaneous pin and strap block
package misc_strap_pkg;
    typedef enum logic [1:0] {
        EE_IDLE = 2'b00,
        EE_LOW = 2'b01,
        EE_HIGH = 2'b11,
        EE_DONE = 2'b10
    } ee_state_e;
endpackage

// File: gp_pin_cell.sv
// One general purpose pin cell with direction and output latch
`timescale 1ns/1ps
module gp_pin_cell (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic dir_wr_i,
    input wire logic dir_d_i,
    input wire logic out_wr_i,
    input wire logic out_d_i,
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe_o,
    output logic in_o
);
    typedef struct packed {
        logic dir;
        logic dout;
        logic din;
    } cell_s;

    cell_s r;
    cell_s next_r;

    // Next state of the cell
    always_comb begin
        next_r = r;
        if (dir_wr_i) begin
            next_r.dir = dir_d_i;
        end
        if (out_wr_i) begin
            next_r.dout = out_d_i;
        end
        next_r.din = pin_i;
    end

    // Registers, input-only after reset
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign pin_o = r.dout;
    assign pin_oe_o = r.dir;
    assign in_o = r.din;
endmodule

// File: ee_serial.sv
// Serial engine for the external EEPROM clock and data pins
`timescale 1ns/1ps
`include "misc_strap_consts.svh"
module ee_serial
    import misc_strap_pkg::*;
#(
    parameter int HALF_CYC = `EE_HALF_CYC,
    parameter int BITS = `EE_BITS
) (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic start_i,
    input wire logic write_i,
    input wire logic [BITS-1:0] wdata_i,
    input wire logic data_i,
    output logic clk_o,
    output logic data_o,
    output logic data_oe_o,
    output logic busy_o,
    output logic [BITS-1:0] rdata_o
);
    typedef struct packed {
        ee_state_e st;
        logic [15:0] div;
        logic [4:0] bitn;
        logic wr;
        logic [BITS-1:0] sh;
        logic sck;
    } ee_s;

    ee_s r;
    ee_s next_r;
    logic tick;

    // Divider pulse for half bit periods
    assign tick = (r.div == 16'(HALF_CYC - 1));

    // Shift sequencer
    always_comb begin
        next_r = r;
        next_r.div = (r.st == EE_IDLE || tick) ? 16'h0000 : r.div + 16'h0001;
        case (r.st)
            EE_IDLE: begin
                next_r.sck = 1'b0;
                if (start_i) begin
                    next_r.st = EE_LOW;
                    next_r.wr = write_i;
                    next_r.sh = wdata_i;
                    next_r.bitn = 5'h00;
                end
            end
            EE_LOW: begin
                if (tick) begin
                    next_r.sck = 1'b1;
                    next_r.st = EE_HIGH;
                    if (!r.wr) begin
                        next_r.sh = {r.sh[BITS-2:0], data_i};
                    end
                end
            end
            EE_HIGH: begin
                if (tick) begin
                    next_r.sck = 1'b0;
                    if (r.wr) begin
                        next_r.sh = {r.sh[BITS-2:0], 1'b1};
                    end
                    if (r.bitn == 5'(BITS - 1)) begin
                        next_r.st = EE_DONE;
                    end else begin
                        next_r.bitn = r.bitn + 5'h01;
                        next_r.st = EE_LOW;
                    end
                end
            end
            EE_DONE: begin
                next_r.st = EE_IDLE;
            end
            default: begin
                next_r.st = EE_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign clk_o = r.sck;
    assign data_o = (r.st != EE_IDLE && r.wr) ? r.sh[BITS-1] : 1'b1;
    assign data_oe_o = (r.st == EE_IDLE) || r.wr;
    assign busy_o = (r.st != EE_IDLE);
    assign rdata_o = r.sh;
endmodule

// File: misc_strap_gpio.sv
// Miscellaneous pins: general purpose pins, straps, test pins and EEPROM port
`timescale 1ns/1ps
`include "misc_strap_consts.svh"

module switch_misc_strap_gpio
    import misc_strap_pkg::*;
#(
    parameter int GP_W = `GP_WIDTH,
    parameter int PORTS = `NUM_PORTS,
    parameter int EE_HALF = `EE_HALF_CYC
) (
    input wire logic CLK_SYS_I,
    input wire logic NRST_I,
    input wire logic [3:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    input wire logic [GP_W-1:0] GP_PIN_I,
    output logic [GP_W-1:0] GP_PIN_O,
    output logic [GP_W-1:0] GP_PIN_OE_O,
    input wire logic SMB_IN_USE_I,
    output logic [2:0] SMB_ADDR_LOW_O,
    output logic [4:0] DEBUG_MODE_SEL_O,
    output logic DEBUG_MODE_O,
    input wire logic POWER_SAVING_STRAP_I,
    output logic POWER_SAVE_EN_O,
    input wire logic MFG_TEST_I,
    input wire logic SCAN_EN_I,
    output logic SCAN_EN_O,
    output logic SCAN_EN_OE_O,
    output logic SCAN_EN_IN_O,
    output logic EEPROM_CLOCK_OUT_O,
    input wire logic EEPROM_SERIAL_DATA_I,
    output logic EEPROM_SERIAL_DATA_O,
    output logic EEPROM_SERIAL_DATA_OE_O,
    input wire logic DEBUG_MODE_ENABLE_PIN_I,
    input wire logic PORT_STATUS_OUTPUT_ENABLE_PIN_I,
    input wire logic [PORTS-1:0] PORT_STATE_I,
    output logic [PORTS-1:0] PORT_STATUS_O,
    output logic [PORTS-1:0] PORT_STATUS_OE_O
);
    typedef struct packed {
        logic strap_done;
        logic pwr_save;
        logic debug;
        logic [2:0] smb_addr;
        logic [4:0] dbg_sel;
        logic [PORTS-1:0] pstat;
        logic pstat_en;
        logic [31:0] rdata;
    } top_s;

    top_s r;
    top_s next_r;
    logic [GP_W-1:0] gp_in;
    logic [GP_W-1:0] gp_dir;
    logic [GP_W-1:0] gp_out;
    logic dir_wr;
    logic out_wr;
    logic ee_busy;
    logic ee_start;
    logic [7:0] ee_rdata;
    logic [31:0] rd_mux;

    // ==========================================
    // Register write decode
    assign dir_wr = WR_I && (ADDR_I == `REG_GP_DIR);
    assign out_wr = WR_I && (ADDR_I == `REG_GP_OUT);
    assign ee_start = WR_I && (ADDR_I == `REG_EE_CTRL) && WDATA_I[`EE_GO] && !ee_busy;

    // ==========================================
    // General purpose pins
    genvar g;
    generate
        for (g = 0; g < GP_W; g++) begin : gp_cells
            gp_pin_cell u_cell (
                .clk_i(CLK_SYS_I),
                .nrst_i(NRST_I),
                .dir_wr_i(dir_wr),
                .dir_d_i(WDATA_I[g]),
                .out_wr_i(out_wr),
                .out_d_i(WDATA_I[g]),
                .pin_i(GP_PIN_I[g]),
                .pin_o(gp_out[g]),
                .pin_oe_o(gp_dir[g]),
                .in_o(gp_in[g])
            );
        end
    endgenerate

    assign GP_PIN_O = gp_out;
    assign GP_PIN_OE_O = gp_dir;

    // ==========================================
    // EEPROM serial port
    ee_serial #(
        .HALF_CYC(EE_HALF),
        .BITS(`EE_BITS)
    ) u_ee (
        .clk_i(CLK_SYS_I),
        .nrst_i(NRST_I),
        .start_i(ee_start),
        .write_i(WDATA_I[`EE_WR]),
        .wdata_i(WDATA_I[15:8]),
        .data_i(EEPROM_SERIAL_DATA_I),
        .clk_o(EEPROM_CLOCK_OUT_O),
        .data_o(EEPROM_SERIAL_DATA_O),
        .data_oe_o(EEPROM_SERIAL_DATA_OE_O),
        .busy_o(ee_busy),
        .rdata_o(ee_rdata)
    );

    // ==========================================
    // Read mux
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (ADDR_I)
            `REG_GP_DIR: rd_mux[GP_W-1:0] = gp_dir;
            `REG_GP_OUT: rd_mux[GP_W-1:0] = gp_out;
            `REG_GP_IN: rd_mux[GP_W-1:0] = gp_in;
            `REG_STATUS: begin
                rd_mux[`ST_PWR_SAVE] = r.pwr_save;
                rd_mux[`ST_DEBUG] = r.debug;
                rd_mux[`ST_SCAN] = MFG_TEST_I;
                rd_mux[`ST_PSTAT_EN] = r.pstat_en;
            end
            `REG_EE_CTRL: rd_mux[15:0] = {ee_rdata, 7'h00, ee_busy};
            `REG_PORT_STAT: rd_mux[PORTS-1:0] = r.pstat;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // ==========================================
    // Strap capture, mode decode and status
    always_comb begin
        next_r = r;
        next_r.rdata = RD_I ? rd_mux : 32'h0000_0000;
        if (!r.strap_done) begin
            next_r.pwr_save = POWER_SAVING_STRAP_I;
            next_r.strap_done = 1'b1;
        end
        next_r.debug = !DEBUG_MODE_ENABLE_PIN_I;
        next_r.smb_addr = SMB_IN_USE_I ? gp_in[`SMB_ADDR_LSB +: 3] : 3'h0;
        next_r.dbg_sel = next_r.debug ? gp_in[`DBG_SEL_LSB +: `DBG_SEL_W] : 5'h00;
        next_r.pstat_en = next_r.debug && PORT_STATUS_OUTPUT_ENABLE_PIN_I;
        next_r.pstat = PORT_STATE_I;
    end

    // Synchronous reset keeps straps to a clocked capture
    always_ff @(posedge CLK_SYS_I) begin
        if (!NRST_I) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // ==========================================
    // Outputs
    assign RDATA_O = r.rdata;
    assign SMB_ADDR_LOW_O = r.smb_addr;
    assign DEBUG_MODE_SEL_O = r.dbg_sel;
    assign DEBUG_MODE_O = r.debug;
    assign POWER_SAVE_EN_O = r.pwr_save;
    assign PORT_STATUS_O = r.pstat;
    assign PORT_STATUS_OE_O = {PORTS{r.pstat_en}};
    assign SCAN_EN_O = 1'b0;
    assign SCAN_EN_OE_O = !MFG_TEST_I;
    assign SCAN_EN_IN_O = MFG_TEST_I ? SCAN_EN_I : 1'b0;
endmodule

// File: misc_strap_chk.sv
// Assertion checker for the miscellaneous pin and strap block
`timescale 1ns/1ps
module misc_strap_chk #(
    parameter int GP_W = 8
) (
    input wire logic CLK_SYS_I,
    input wire logic NRST_I,
    input wire logic [GP_W-1:0] GP_PIN_I,
    input wire logic [GP_W-1:0] GP_PIN_OE_O,
    input wire logic SMB_IN_USE_I,
    input wire logic [2:0] SMB_ADDR_LOW_O,
    input wire logic DEBUG_MODE_ENABLE_PIN_I,
    input wire logic [4:0] DEBUG_MODE_SEL_O,
    input wire logic MFG_TEST_I,
    input wire logic SCAN_EN_O,
    input wire logic SCAN_EN_OE_O,
    input wire logic POWER_SAVING_STRAP_I,
    input wire logic POWER_SAVE_EN_O
);
    // ==========
    // Pin relations on the system clock
    default clocking @(posedge CLK_SYS_I); endclocking
    default disable iff (!NRST_I);
    // Pins held still long enough to pass the input registers
    sequence smb_held_s;
        (SMB_IN_USE_I && $stable(GP_PIN_I))[*4];
    endsequence
    sequence dbg_held_s;
        (!DEBUG_MODE_ENABLE_PIN_I && $stable(GP_PIN_I))[*4];
    endsequence
    a_scan_low: assert property (!SCAN_EN_O && SCAN_EN_OE_O == !MFG_TEST_I)
        else $error("scan pin wrong");
    a_gp_input_reset: assert property ($rose(NRST_I) |-> GP_PIN_OE_O == '0)
        else $error("pin driven after reset");
    a_smb_addr_pins: assert property (smb_held_s |-> SMB_ADDR_LOW_O == GP_PIN_I[7:5])
        else $error("address bits wrong");
    a_smb_addr_off: assert property ((!SMB_IN_USE_I)[*3] |-> SMB_ADDR_LOW_O == 3'h0)
        else $error("address bits set");
    a_dbg_sel_pins: assert property (dbg_held_s |-> DEBUG_MODE_SEL_O == GP_PIN_I[4:0])
        else $error("selection code wrong");
    a_dbg_sel_off: assert property (DEBUG_MODE_ENABLE_PIN_I[*3] |-> DEBUG_MODE_SEL_O == 5'h0)
        else $error("selection code set");
    a_strap_take: assert property ($rose(NRST_I) |=> POWER_SAVE_EN_O == $past(POWER_SAVING_STRAP_I))
        else $error("strap not taken");
    a_strap_hold: assert property ($past(NRST_I) && $past(NRST_I, 2) |-> $stable(POWER_SAVE_EN_O))
        else $error("power save moved");
endmodule

bind switch_misc_strap_gpio misc_strap_chk #(.GP_W(GP_W)) misc_strap_chk_i (
    .CLK_SYS_I(CLK_SYS_I), .NRST_I(NRST_I), .GP_PIN_I(GP_PIN_I), .GP_PIN_OE_O(GP_PIN_OE_O),
    .SMB_IN_USE_I(SMB_IN_USE_I), .SMB_ADDR_LOW_O(SMB_ADDR_LOW_O),
    .DEBUG_MODE_ENABLE_PIN_I(DEBUG_MODE_ENABLE_PIN_I), .DEBUG_MODE_SEL_O(DEBUG_MODE_SEL_O),
    .MFG_TEST_I(MFG_TEST_I), .SCAN_EN_O(SCAN_EN_O), .SCAN_EN_OE_O(SCAN_EN_OE_O),
    .POWER_SAVING_STRAP_I(POWER_SAVING_STRAP_I), .POWER_SAVE_EN_O(POWER_SAVE_EN_O));

// File: ee_model.sv
// Serial EEPROM stand-in on the clock and data pins
`timescale 1ns/1ps
module ee_model (
    input wire logic clk_i,
    input wire logic ee_clk_i,
    input wire logic dev_d_i,
    input wire logic dev_oe_i,
    input wire logic [7:0] rbyte_i,
    output logic line_o,
    output logic [7:0] cap_o
);
    // ==========
    // Data line and shifters
    logic [3:0] idx = 4'h0;
    logic last = 1'b0;
    // answers MSB first, released line toggles
    assign line_o = dev_oe_i ? dev_d_i : (idx[3] ? ~last : rbyte_i[~idx[2:0]]);
    // Line history
    always @(posedge clk_i) last <= line_o;
    // Bit index steps after each falling clock
    always @(negedge ee_clk_i or posedge dev_oe_i) idx <= dev_oe_i ? 4'h0 : idx + 4'h1;
    // Written bits taken on the rising clock
    always @(posedge ee_clk_i) cap_o <= {cap_o[6:0], line_o};
endmodule

// File: test_switch_misc_strap_gpio.sv
// Self-checking bench for the miscellaneous pin and strap block
`timescale 1ns/1ps
module test_switch_misc_strap_gpio;
    // ==========
    // Stimulus and observed signals
    logic clk, nrst = 1'b0, wr = 1'b0, rd = 1'b0, smb = 1'b0, strap = 1'b1, mfg = 1'b0, sc_x = 1'b0;
    logic dpin = 1'b1, pse = 1'b0, dbg, psave, sc_o, sc_oe, sc_rx, eclk, e_o, e_oe, eline;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata;
    logic [7:0] gx = 8'h00, rbyte = 8'h5a, g_o, g_oe, cap;
    logic [2:0] pst = 3'h0, smb_a, ps_o, ps_oe;
    logic [4:0] sel;
    int num_errors = 0, cmp_count = 0, cyc = 0;
    // Board levels on the two-way pins
    wire logic [7:0] g_in = (g_oe & g_o) | (~g_oe & gx);
    wire logic sc_in = sc_oe ? sc_o : sc_x;
    switch_misc_strap_gpio #(.EE_HALF(2)) switch_misc_strap_gpio_i (
        .CLK_SYS_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
        .GP_PIN_I(g_in), .GP_PIN_O(g_o), .GP_PIN_OE_O(g_oe), .SMB_IN_USE_I(smb), .SMB_ADDR_LOW_O(smb_a),
        .DEBUG_MODE_SEL_O(sel), .DEBUG_MODE_O(dbg), .POWER_SAVING_STRAP_I(strap), .POWER_SAVE_EN_O(psave),
        .MFG_TEST_I(mfg), .SCAN_EN_I(sc_in), .SCAN_EN_O(sc_o), .SCAN_EN_OE_O(sc_oe), .SCAN_EN_IN_O(sc_rx),
        .EEPROM_CLOCK_OUT_O(eclk), .EEPROM_SERIAL_DATA_I(eline), .EEPROM_SERIAL_DATA_O(e_o),
        .EEPROM_SERIAL_DATA_OE_O(e_oe), .DEBUG_MODE_ENABLE_PIN_I(dpin), .PORT_STATUS_OUTPUT_ENABLE_PIN_I(pse),
        .PORT_STATE_I(pst), .PORT_STATUS_O(ps_o), .PORT_STATUS_OE_O(ps_oe));
    ee_model ee_model_i (.clk_i(clk), .ee_clk_i(eclk), .dev_d_i(e_o), .dev_oe_i(e_oe), .rbyte_i(rbyte),
        .line_o(eline), .cap_o(cap));
    // Clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            num_errors++;
            stop_test();
        end
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task stop_test();
        $display("checks=%0d errors=%0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [3:0] a, output logic [31:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask
    task t_reset();
        logic [31:0] v;
        chk(g_oe, 32'h0);
        chk(psave, 32'h1);
        rd_reg(4'h0, v);
        chk(v, 32'h0);
        strap <= 1'b0;
        tick(3);
        chk(psave, 32'h1);
        nrst <= 1'b0;
        tick(2);
        nrst <= 1'b1;
        tick(2);
        chk(psave, 32'h0);
    endtask
    task t_gpio();
        logic [31:0] v;
        gx <= 8'h0f;
        wr_reg(4'h0, 32'ha5);
        wr_reg(4'h1, 32'h3c);
        tick(3);
        chk(g_oe, 32'ha5);
        chk(g_o, 32'h3c);
        rd_reg(4'h2, v);
        chk(v, (32'ha5 & 32'h3c) | (~32'ha5 & 32'h0f));
        rd_reg(4'h7, v);
        chk(v, 32'h0);
        nrst <= 1'b0;
        tick(2);
        chk(g_oe, 32'h0);
        nrst <= 1'b1;
        tick(2);
    endtask
    task t_pins();
        logic [31:0] v;
        gx <= 8'hb3;
        smb <= 1'b1;
        pst <= 3'h5;
        dpin <= 1'b0;
        pse <= 1'b1;
        tick(4);
        chk(smb_a, 32'h5);
        chk(dbg, 32'h1);
        chk(sel, 32'h13);
        chk({ps_oe, ps_o}, 32'h3d);
        rd_reg(4'h3, v);
        chk(v, 32'ha);
        rd_reg(4'h5, v);
        chk(v, 32'h5);
        smb <= 1'b0;
        pse <= 1'b0;
        tick(3);
        chk({smb_a, ps_oe}, 32'h0);
        dpin <= 1'b1;
        tick(3);
        chk({dbg, sel}, 32'h0);
    endtask
    task t_scan();
        chk({sc_oe, sc_o}, 32'h2);
        mfg <= 1'b1;
        sc_x <= 1'b1;
        tick(2);
        chk({sc_oe, sc_rx}, 32'h1);
        mfg <= 1'b0;
    endtask
    task ee_wait();
        logic [31:0] v;
        v = 32'h1;
        for (int i = 0; i < 100 && v[0]; i++) rd_reg(4'h4, v);
        chk(v[0], 32'h0);
    endtask
    // byte out, byte in, idle levels
    task t_ee();
        logic [31:0] v;
        chk({e_oe, e_o, eclk}, 32'h6);
        wr_reg(4'h4, 32'h9603);
        // Second start while busy must be ignored
        wr_reg(4'h4, 32'h0003);
        ee_wait();
        chk(cap, 32'h96);
        wr_reg(4'h4, 32'h1);
        ee_wait();
        rd_reg(4'h4, v);
        chk(v[15:8], {24'h0, rbyte});
        tick(2);
        chk({e_oe, e_o, eclk}, 32'h6);
    endtask
    // Main sequence
    initial begin
        tick(2);
        nrst <= 1'b1;
        tick(2);
        t_reset();
        t_gpio();
        t_pins();
        t_scan();
        t_ee();
        stop_test();
    end
endmodule
